// ---- logic/comp_ctrl_pkg.sv ----
// constants, codes and state type for the comparator control logic
package comp_ctrl_pkg;

   // register byte offsets
   localparam logic [11:0] OFS_TASK_START = 12'h000;
   localparam logic [11:0] OFS_TASK_STOP = 12'h004;
   localparam logic [11:0] OFS_TASK_SAMPLE = 12'h008;
   localparam logic [11:0] OFS_EV_READY = 12'h100;
   localparam logic [11:0] OFS_EV_DOWN = 12'h104;
   localparam logic [11:0] OFS_EV_UP = 12'h108;
   localparam logic [11:0] OFS_EV_CROSS = 12'h10C;
   localparam logic [11:0] OFS_SHORTS = 12'h200;
   localparam logic [11:0] OFS_INTEN = 12'h300;
   localparam logic [11:0] OFS_INTENSET = 12'h304;
   localparam logic [11:0] OFS_INTENCLR = 12'h308;
   localparam logic [11:0] OFS_RESULT = 12'h400;
   localparam logic [11:0] OFS_ENABLE = 12'h500;
   localparam logic [11:0] OFS_PSEL = 12'h504;
   localparam logic [11:0] OFS_REF_SOURCE = 12'h508;
   localparam logic [11:0] OFS_EXT_REF_PIN = 12'h50C;
   localparam logic [11:0] OFS_THRESHOLD = 12'h530;
   localparam logic [11:0] OFS_MODE = 12'h534;
   localparam logic [11:0] OFS_HYSTERESIS = 12'h538;

   // event and shortcut bit indices
   localparam int EV_READY = 0;
   localparam int EV_DOWN = 1;
   localparam int EV_UP = 2;
   localparam int EV_CROSS = 3;
   localparam int SH_READY_SAMPLE = 0;
   localparam int SH_READY_STOP = 1;
   localparam int SH_DOWN_STOP = 2;
   localparam int SH_UP_STOP = 3;
   localparam int SH_CROSS_STOP = 4;

   // field positions
   localparam int THRESH_LOWER_LSB = 0;
   localparam int THRESH_UPPER_LSB = 8;
   localparam int MODE_SPEED_LSB = 0;
   localparam int MODE_DIFF_BIT = 8;
   localparam int LADDER_BITS = 6;
   localparam int LADDER_LEVELS = 64;

   // field codes
   localparam logic [1:0] ENABLE_ON = 2'h2;
   localparam logic [1:0] SPEED_LOW_POWER = 2'h0;
   localparam logic [1:0] SPEED_NORMAL = 2'h1;
   localparam logic [1:0] SPEED_HIGH = 2'h2;
   localparam logic [2:0] PSEL_DIVIDED_HIGH_SUPPLY = 3'h7;
   localparam logic [2:0] REF_INT_1V2 = 3'h0;
   localparam logic [2:0] REF_INT_1V8 = 3'h1;
   localparam logic [2:0] REF_INT_2V4 = 3'h2;
   localparam logic [2:0] REF_SUPPLY = 3'h4;
   localparam logic [2:0] ANALOG_PIN_REFERENCE_OPTION = 3'h5;

   // startup timing, times in ns, counts in cycles (load value is count - 1)
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_INT_REF_START_NS = 5000;
   localparam int T_COMP_START_NS = 2000;
   localparam int INT_REF_START_CYC = (T_INT_REF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COMP_START_CYC = (T_COMP_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] INT_REF_START_LOAD = 16'(INT_REF_START_CYC - 1);
   localparam logic [15:0] COMP_START_LOAD = 16'(COMP_START_CYC - 1);

   // run sequencing states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STARTING = 2'b01,
      ST_RUNNING = 2'b10
   } run_state_t;

   // complete block state
   typedef struct packed {
      run_state_t st;
      logic ack;
      logic [31:0] rdata;
      logic sync1;
      logic sync2;
      logic prev;
      logic [3:0] events;
      logic [4:0] shorts;
      logic [3:0] inten;
      logic result;
      logic [1:0] enable;
      logic [2:0] psel;
      logic [2:0] ref_source;
      logic [2:0] extref;
      logic [5:0] thresh_lo;
      logic [5:0] thresh_hi;
      logic [1:0] speed;
      logic diff;
      logic hysteresis_en;
      logic [5:0] ladder;
      logic [15:0] cnt;
   } comp_state_t;

   localparam comp_state_t STATE_RST = '0;

endpackage

// ---- logic/comparator_control_logic.sv ----
// register slave, run sequencing and event logic of the voltage comparator
//
// Summary of operation
// RULE_01 - start task runs, stop task halts comparator
// RULE_02 - ready event only once output valid
// RULE_03 - startup delay depends on reference type
// RULE_04 - every crossing while running makes event
// RULE_05 - up, down events; cross on both
// RULE_06 - differential or single-ended mode selectable
// RULE_07 - low-power, normal or high-speed setting
// RULE_08 - positive input from pin or divided supply
// RULE_09 - differential negative input from chosen pin
// RULE_10 - single-ended reference: supply, pin, internal
// RULE_11 - pins connect as soon as enabled
// RULE_12 - differential hysteresis enable adds hysteresis
// RULE_13 - sample task captures instantaneous output
// RULE_14 - software configures differential before enabling
// RULE_15 - differential hysteresis symmetric half span
// RULE_16 - software configures single-ended before enabling
// RULE_17 - ladder gives upper and lower thresholds
// RULE_18 - ladder has sixty-four selectable levels
// RULE_19 - pin reference picked by external select
// RULE_20 - above uses lower threshold, below upper
// RULE_21 - hysteresis enable ignored in single-ended mode
// RULE_22 - result zero below, one above
// RULE_23 - shortcut samples result on ready event
// RULE_24 - event flags sticky, gated onto interrupt
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module comparator_control_logic
   import comp_ctrl_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // avalon-mm slave
   input wire logic [11:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // analog core output
   input wire logic comp_out_i,
   // analog core control
   output logic analog_connect_o,
   output logic core_on_o,
   output logic diff_mode_o,
   output logic diff_hysteresis_on_o,
   output logic [1:0] speed_o,
   output logic [2:0] pos_sel_o,
   output logic [2:0] ext_ref_sel_o,
   output logic [2:0] ref_src_o,
   output logic [5:0] ladder_level_o,
   // status
   output logic ready_o,
   output logic irq_o
);

   comp_state_t s;
   comp_state_t n;
   logic req;
   logic wr;
   logic en;
   logic start_task;
   logic stop_task;
   logic sample_task;
   logic ready_pulse;
   logic up_pulse;
   logic down_pulse;
   logic [3:0] ev_set;
   logic [31:0] rd;
   logic [31:0] old_word;
   logic [31:0] wword;

   // byte-lane merge of a write onto the current word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // readback word of the addressed register
   always_comb begin
      rd = 32'h0000_0000;
      case (address_i)
         OFS_EV_READY: rd[0] = s.events[EV_READY];
         OFS_EV_DOWN: rd[0] = s.events[EV_DOWN];
         OFS_EV_UP: rd[0] = s.events[EV_UP];
         OFS_EV_CROSS: rd[0] = s.events[EV_CROSS];
         OFS_SHORTS: rd[4:0] = s.shorts;
         OFS_INTEN: rd[3:0] = s.inten;
         OFS_INTENSET: rd[3:0] = s.inten;
         OFS_INTENCLR: rd[3:0] = s.inten;
         // RULE_22 result polarity
         OFS_RESULT: rd[0] = s.result;
         OFS_ENABLE: rd[1:0] = s.enable;
         OFS_PSEL: rd[2:0] = s.psel;
         OFS_REF_SOURCE: rd[2:0] = s.ref_source;
         OFS_EXT_REF_PIN: rd[2:0] = s.extref;
         OFS_THRESHOLD: begin
            rd[THRESH_LOWER_LSB +: LADDER_BITS] = s.thresh_lo;
            rd[THRESH_UPPER_LSB +: LADDER_BITS] = s.thresh_hi;
         end
         OFS_MODE: begin
            rd[MODE_SPEED_LSB +: 2] = s.speed;
            rd[MODE_DIFF_BIT] = s.diff;
         end
         OFS_HYSTERESIS: rd[0] = s.hysteresis_en;
         default: rd = 32'h0000_0000;
      endcase
   end

   // next state of the whole block
   always_comb begin
      n = s;
      req = read_i | write_i;
      wr = write_i & s.ack;
      en = (s.enable == ENABLE_ON);
      old_word = rd;
      wword = merge(old_word, writedata_i, byteenable_i);
      ready_pulse = 1'b0;
      up_pulse = 1'b0;
      down_pulse = 1'b0;
      // one wait cycle, read data registered before release
      n.ack = req & ~s.ack;
      if (read_i & ~s.ack) begin
         n.rdata = rd;
      end
      n.sync1 = comp_out_i;
      n.sync2 = s.sync1;
      start_task = wr & (address_i == OFS_TASK_START) & wword[0];
      stop_task = wr & (address_i == OFS_TASK_STOP) & wword[0];
      sample_task = wr & (address_i == OFS_TASK_SAMPLE) & wword[0];
      // configuration writes
      if (wr) begin
         case (address_i)
            OFS_EV_READY: n.events[EV_READY] = wword[0];
            OFS_EV_DOWN: n.events[EV_DOWN] = wword[0];
            OFS_EV_UP: n.events[EV_UP] = wword[0];
            OFS_EV_CROSS: n.events[EV_CROSS] = wword[0];
            OFS_SHORTS: n.shorts = wword[4:0];
            OFS_INTEN: n.inten = wword[3:0];
            OFS_INTENSET: n.inten = s.inten | wword[3:0];
            OFS_INTENCLR: n.inten = s.inten & ~wword[3:0];
            OFS_ENABLE: n.enable = wword[1:0];
            OFS_PSEL: n.psel = wword[2:0];
            OFS_REF_SOURCE: n.ref_source = wword[2:0];
            OFS_EXT_REF_PIN: n.extref = wword[2:0];
            OFS_THRESHOLD: begin
               n.thresh_lo = wword[THRESH_LOWER_LSB +: LADDER_BITS];
               n.thresh_hi = wword[THRESH_UPPER_LSB +: LADDER_BITS];
            end
            OFS_MODE: begin
               n.speed = wword[MODE_SPEED_LSB +: 2];
               n.diff = wword[MODE_DIFF_BIT];
            end
            // RULE_21 write dropped single-ended
            OFS_HYSTERESIS: n.hysteresis_en = s.diff ? wword[0] : s.hysteresis_en;
            default: n = n;
         endcase
      end
      // RULE_13 sample task capture
      if (sample_task & en) begin
         n.result = s.sync2;
      end
      // run sequencing
      case (s.st)
         ST_IDLE: begin
            // RULE_01 start when enabled
            if (start_task & en) begin
               n.st = ST_STARTING;
               // RULE_03 startup delay choice
               if (!s.diff && (s.ref_source == REF_INT_1V2 || s.ref_source == REF_INT_1V8 ||
                               s.ref_source == REF_INT_2V4)) begin
                  n.cnt = INT_REF_START_LOAD;
               end else begin
                  n.cnt = COMP_START_LOAD;
               end
            end
         end
         ST_STARTING: begin
            if (stop_task | ~en) begin
               n.st = ST_IDLE;
            end else if (s.cnt == 16'h0000) begin
               // RULE_02 ready after startup
               ready_pulse = 1'b1;
               n.prev = s.sync2;
               n.st = s.shorts[SH_READY_STOP] ? ST_IDLE : ST_RUNNING;
               // RULE_23 ready to sample shortcut
               if (s.shorts[SH_READY_SAMPLE]) begin
                  n.result = s.sync2;
               end
            end else begin
               n.cnt = s.cnt - 16'h0001;
            end
         end
         ST_RUNNING: begin
            // RULE_04 crossing detection
            up_pulse = s.sync2 & ~s.prev;
            down_pulse = ~s.sync2 & s.prev;
            n.prev = s.sync2;
            // RULE_01 stop task or shortcut
            if (stop_task | ~en |
                (up_pulse & (s.shorts[SH_UP_STOP] | s.shorts[SH_CROSS_STOP])) |
                (down_pulse & (s.shorts[SH_DOWN_STOP] | s.shorts[SH_CROSS_STOP]))) begin
               n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // RULE_05 event classification
      ev_set = 4'h0;
      ev_set[EV_READY] = ready_pulse;
      ev_set[EV_UP] = up_pulse;
      ev_set[EV_DOWN] = down_pulse;
      ev_set[EV_CROSS] = up_pulse | down_pulse;
      // RULE_24 set wins over clear
      n.events = n.events | ev_set;
      // RULE_20 ladder follows output
      n.ladder = s.sync2 ? s.thresh_lo : s.thresh_hi;
   end

   // state register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s <= STATE_RST;
      end else begin
         s <= n;
      end
   end

   // bus outputs
   assign waitrequest_o = req & ~s.ack;
   assign readdata_o = s.rdata;

   // RULE_11 pins connected while enabled
   assign analog_connect_o = (s.enable == ENABLE_ON);
   assign core_on_o = (s.st != ST_IDLE);
   assign ready_o = (s.st == ST_RUNNING);
   // RULE_06 main mode to core
   assign diff_mode_o = s.diff;
   // RULE_12 RULE_15 differential hysteresis enable
   assign diff_hysteresis_on_o = s.diff & s.hysteresis_en;
   // RULE_07 speed setting to core
   assign speed_o = s.speed;
   // RULE_08 positive input select
   assign pos_sel_o = s.psel;
   // RULE_09 RULE_19 external pin select
   assign ext_ref_sel_o = s.extref;
   // RULE_10 reference source select
   assign ref_src_o = s.ref_source;
   // RULE_17 RULE_18 active ladder level
   assign ladder_level_o = s.ladder;
   // RULE_24 masked event interrupt
   assign irq_o = |(s.events & s.inten);

   // helper: cycles spent starting and the delay expected
   logic [15:0] cyc_r;
   logic [15:0] exp_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cyc_r <= 16'h0000;
         exp_r <= 16'h0000;
      end else begin
         cyc_r <= (n.st == ST_STARTING && s.st == ST_STARTING) ? cyc_r + 16'h0001 : 16'h0000;
         exp_r <= (s.st == ST_IDLE) ? n.cnt : exp_r;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence start_req_s;
      (s.st == ST_IDLE) && start_task && en;
   endsequence

   sequence ready_step_s;
      (s.st == ST_STARTING) && (s.cnt == 16'h0000) && !stop_task && en;
   endsequence

   sequence rise_seen_s;
      (s.st == ST_RUNNING) && s.sync2 && !s.prev;
   endsequence

   start_enter_a: assert property (start_req_s |=> s.st == ST_STARTING) // RULE_01
      else $error("start task did not start comparator");
   stop_leave_a: assert property ((stop_task && s.st != ST_IDLE) |=> s.st == ST_IDLE) // RULE_01
      else $error("stop task did not stop comparator");
   ready_valid_a: assert property (ready_step_s |=> s.events[EV_READY]) // RULE_02
      else $error("ready event missing after startup");
   ready_time_a: assert property (ready_pulse |-> cyc_r == exp_r) // RULE_03
      else $error("startup delay has wrong length");
   cross_event_a: assert property (rise_seen_s |=> s.events[EV_UP] && s.events[EV_CROSS]) // RULE_05
      else $error("upward crossing lost");
   fall_event_a: assert property (((s.st == ST_RUNNING) && !s.sync2 && s.prev) // RULE_04
      |=> s.events[EV_DOWN] && s.events[EV_CROSS])
      else $error("downward crossing lost");
   sample_capture_a: assert property ((sample_task && en) |=> s.result == $past(s.sync2)) // RULE_13
      else $error("sample did not capture output");
   ladder_switch_a: assert property ((s.sync2 && $stable(s.thresh_lo)) // RULE_20
      ##1 $stable(s.thresh_lo) |-> s.ladder == s.thresh_lo)
      else $error("ladder not at lower threshold while above");
   hysteresis_ignore_a: assert property ((wr && !s.diff) // RULE_21
      && address_i == OFS_HYSTERESIS |=> $stable(s.hysteresis_en))
      else $error("hysteresis enable changed in single-ended mode");
   connect_enable_a: assert property ($rose(s.enable == ENABLE_ON) |-> analog_connect_o) // RULE_11
      else $error("pins not connected on enable");
   flag_hold_a: assert property ((s.events[EV_CROSS] && !(wr && address_i == OFS_EV_CROSS)) // RULE_24
      |=> s.events[EV_CROSS])
      else $error("cross flag dropped without clear");
   irq_gate_a: assert property ((s.events[EV_UP] && s.inten[EV_UP]) |-> irq_o) // RULE_24
      else $error("enabled event did not raise interrupt");

endmodule

// ---- verification/comp_analog_model.sv ----
// behavioural analog comparator core facing the control logic
`timescale 1ns/1ps
module comp_analog_model
   import comp_ctrl_pkg::*;
#(
   parameter int HALF_SPAN = 2
)
(
   // clock
   input wire logic mclk_i,
   // control from the block
   input wire logic core_on_i,
   input wire logic diff_mode_i,
   input wire logic diff_hysteresis_on_i,
   input wire logic [1:0] speed_i,
   input wire logic [5:0] ladder_level_i,
   // analog levels set by the bench
   input wire logic [6:0] pos_level_i,
   input wire logic [6:0] neg_level_i,
   // comparator output
   output logic comp_out_o
);
   logic [6:0] neg;
   logic state = 1'b0;
   logic tog = 1'b0;
   logic [3:0] pipe = 4'h0;

   assign neg = diff_mode_i ? neg_level_i : {1'b0, ladder_level_i};

   // decision with optional symmetric hysteresis; unpowered output wanders
   always @(posedge mclk_i) begin
      tog <= ~tog;
      if (!(diff_mode_i && diff_hysteresis_on_i)) begin
         state <= pos_level_i > neg;
      end else if (int'(pos_level_i) > int'(neg) + HALF_SPAN) begin
         state <= 1'b1;
      end else if (int'(pos_level_i) + HALF_SPAN < int'(neg)) begin
         state <= 1'b0;
      end
      pipe <= {pipe[2:0], state};
   end

   assign comp_out_o = !core_on_i ? tog : (speed_i == SPEED_HIGH) ? pipe[0] :
      (speed_i == SPEED_NORMAL) ? pipe[1] : pipe[3];
endmodule

// ---- verification/comparator_control_logic_bench.sv ----
// self-checking bench for the comparator control logic
`timescale 1ns/1ps
module comparator_control_logic_bench;
   import comp_ctrl_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [11:0] address_i = 12'h000;
   logic [31:0] writedata_i = 32'h0;
   logic [3:0] byteenable_i = 4'h0;
   logic [31:0] readdata_o;
   logic waitrequest_o, comp_out_i, analog_connect_o, core_on_o, diff_mode_o;
   logic diff_hysteresis_on_o, ready_o, irq_o;
   logic [1:0] speed_o;
   logic [2:0] pos_sel_o, ext_ref_sel_o, ref_src_o;
   logic [5:0] ladder_level_o;
   logic [6:0] pos_lvl = 7'h0A;
   logic [6:0] neg_lvl = 7'h20;
   int failures = 0;
   int checks = 0;
   logic [2:0] refs [5] = '{REF_INT_1V2, REF_INT_1V8, REF_INT_2V4, REF_SUPPLY,
      ANALOG_PIN_REFERENCE_OPTION};

   // clock
   always #5 mclk_i = ~mclk_i;

   comparator_control_logic u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .comp_out_i(comp_out_i), .analog_connect_o(analog_connect_o), .core_on_o(core_on_o),
      .diff_mode_o(diff_mode_o), .diff_hysteresis_on_o(diff_hysteresis_on_o), .speed_o(speed_o),
      .pos_sel_o(pos_sel_o), .ext_ref_sel_o(ext_ref_sel_o), .ref_src_o(ref_src_o),
      .ladder_level_o(ladder_level_o), .ready_o(ready_o), .irq_o(irq_o));

   comp_analog_model u_model (.mclk_i(mclk_i), .core_on_i(core_on_o),
      .diff_mode_i(diff_mode_o), .diff_hysteresis_on_i(diff_hysteresis_on_o), .speed_i(speed_o),
      .ladder_level_i(ladder_level_o), .pos_level_i(pos_lvl), .neg_level_i(neg_lvl),
      .comp_out_o(comp_out_i));

   // compare and count
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low at a rising edge
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      @(posedge mclk_i);
      address_i <= a;
      writedata_i <= d;
      byteenable_i <= 4'hF;
      read_i <= !wr;
      write_i <= wr;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 100);
      if (n >= 100) failures++;
      q = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      // written register settles before outputs are looked at
      @(negedge mclk_i);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   // start and count cycles until ready
   task start_ready(input int n_exp);
      int n;
      wr(OFS_TASK_START, 32'h1);
      check(32'(core_on_o), 32'h1);
      n = 0;
      while (ready_o !== 1'b1 && n < 1000) begin
         @(negedge mclk_i);
         n++;
      end
      check(32'(n), 32'(n_exp));
   endtask

   task settle;
      repeat (12) @(posedge mclk_i);
   endtask

   task end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (30000) @(posedge mclk_i);
      failures++;
      end_of_test();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      check(32'(analog_connect_o), 32'h0);
      rd(OFS_RESULT, 32'h0);
      rd(12'h600, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_MODE, 32'(i));
         check(32'(speed_o), 32'(i));
      end
      for (int i = 0; i < 8; i++) begin
         wr(OFS_PSEL, 32'(i));
         check(32'(pos_sel_o), 32'(i));
      end
      for (int i = 0; i < 5; i++) begin
         wr(OFS_REF_SOURCE, 32'(refs[i]));
         check(32'(ref_src_o), 32'(refs[i]));
      end
      wr(OFS_EXT_REF_PIN, 32'h7);
      check(32'(ext_ref_sel_o), 32'h7);
      wr(OFS_THRESHOLD, 32'hFFFFFFFF);
      rd(OFS_THRESHOLD, 32'h00003F3F);
      wr(OFS_MODE, 32'h0);
      wr(OFS_HYSTERESIS, 32'h1);
      rd(OFS_HYSTERESIS, 32'h0);
      wr(OFS_MODE, 32'h102);
      wr(OFS_HYSTERESIS, 32'h1);
      check(32'({diff_mode_o, diff_hysteresis_on_o}), 32'h3);
      wr(OFS_MODE, 32'h2);
      check(32'(diff_hysteresis_on_o), 32'h0);
      wr(OFS_PSEL, 32'h0);
      wr(OFS_MODE, 32'h102);
      wr(OFS_EXT_REF_PIN, 32'h3);
      check(32'(ext_ref_sel_o), 32'h3);
      wr(OFS_ENABLE, 32'(ENABLE_ON));
      check(32'({analog_connect_o, core_on_o}), 32'h2);
      start_ready(COMP_START_CYC);
      rd(OFS_EV_READY, 32'h1);
      // inside half the hysteresis span: no crossing may be seen
      pos_lvl <= 7'h21;
      settle();
      rd(OFS_EV_UP, 32'h0);
      pos_lvl <= 7'h28;
      settle();
      rd(OFS_EV_UP, 32'h1);
      rd(OFS_EV_CROSS, 32'h1);
      rd(OFS_EV_DOWN, 32'h0);
      wr(OFS_EV_UP, 32'h0);
      wr(OFS_EV_CROSS, 32'h0);
      wr(OFS_TASK_SAMPLE, 32'h1);
      rd(OFS_RESULT, 32'h1);
      pos_lvl <= 7'h0A;
      settle();
      rd(OFS_EV_DOWN, 32'h1);
      rd(OFS_EV_CROSS, 32'h1);
      rd(OFS_EV_UP, 32'h0);
      wr(OFS_TASK_SAMPLE, 32'h1);
      rd(OFS_RESULT, 32'h0);
      wr(OFS_INTENSET, 32'h1 << EV_DOWN);
      @(negedge mclk_i);
      check(32'(irq_o), 32'h1);
      wr(OFS_INTENCLR, 32'h1 << EV_DOWN);
      @(negedge mclk_i);
      check(32'(irq_o), 32'h0);
      rd(OFS_INTEN, 32'h0);
      wr(OFS_TASK_STOP, 32'h1);
      @(negedge mclk_i);
      check(32'({core_on_o, ready_o}), 32'h0);
      for (int i = 0; i < 4; i++) wr(OFS_EV_READY + 12'(4 * i), 32'h0);
      pos_lvl <= 7'h28;
      settle();
      rd(OFS_EV_CROSS, 32'h0);
      wr(OFS_ENABLE, 32'h0);
      wr(OFS_PSEL, 32'h1);
      wr(OFS_MODE, 32'h1);
      wr(OFS_REF_SOURCE, 32'(REF_INT_1V8));
      wr(OFS_EXT_REF_PIN, 32'h0);
      wr(OFS_THRESHOLD, 32'h0000140A);
      wr(OFS_SHORTS, 32'h1);
      wr(OFS_ENABLE, 32'(ENABLE_ON));
      pos_lvl <= 7'h1E;
      start_ready(INT_REF_START_CYC);
      settle();
      rd(OFS_RESULT, 32'h1);
      check(32'(ladder_level_o), 32'h0A);
      pos_lvl <= 7'h0F;
      settle();
      check(32'(ladder_level_o), 32'h0A);
      rd(OFS_EV_DOWN, 32'h0);
      pos_lvl <= 7'h05;
      settle();
      check(32'(ladder_level_o), 32'h14);
      rd(OFS_EV_DOWN, 32'h1);
      pos_lvl <= 7'h0F;
      settle();
      rd(OFS_EV_UP, 32'h0);
      wr(OFS_TASK_STOP, 32'h1);
      wr(OFS_ENABLE, 32'h0);
      wr(OFS_REF_SOURCE, 32'(REF_SUPPLY));
      wr(OFS_ENABLE, 32'(ENABLE_ON));
      start_ready(COMP_START_CYC);
      $display("all tests done");
      end_of_test();
   end
endmodule
